/* src/ptf_formatter.sv */
`timescale 1ns/1ps
// How it works
// - Forward one goes to erase polarity.
// - Every bit cell transitions at bit time.
// - Equal neighbour bits get phase transition.
// - Differing neighbour bits: no phase transition.
// - 1600 bpi, optional 3200 bpi density.
// - Channels 0..7 data MSB first, P parity.
// - Parity makes each data character odd.
// - No CRC or LRC characters appended.
// - Preamble: forty zeros then all ones.
// - Reader syncs on ones after zero run.
// - Postamble: all ones then forty zeros.
// - 1600 burst in channel P, rest erased.
// - 3200 burst goes in channel zero.
// - File mark: 40 chars, fixed channel set.
// - Cache counts records and bytes, limited.
// - Host stalls while a limit is reached.
// - Near tape end, limits shrink.
// - Missed reinstruct deadline triggers repositioning.
// - Reposition: decel fwd, accel rev, decel.
// - Timely same command keeps tape streaming.
// - Opposite direction adds extra repositioning.
// - Reverse peak speed equals 100 ips.
// - Strobe pulses per character taken.

// ----------------------------------------------------------------
// Write cache FIFO
// ----------------------------------------------------------------
module ptf_fifo #(
	parameter int W = 9,
	parameter int D = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [W-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [$clog2(D):0] count
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0] wp_q, rp_q;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;
	assign count = wp_q - rp_q;
	assign in_ready = count != (AW+1)'(D);
	assign out_valid = wp_q != rp_q;
	assign out_data = mem[rp_q[AW-1:0]];
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_q[AW-1:0]] <= in_data;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			wp_q <= wp_q + (AW+1)'(push);
			rp_q <= rp_q + (AW+1)'(pop);
		end
	end
endmodule

// ----------------------------------------------------------------
// Block formatter, cache control and streaming motion
// ----------------------------------------------------------------
module ptf_formatter import ptf_pkg::*; #(
	parameter int DEPTH = 16,
	parameter int REINSTRUCT = REINSTRUCT_CYC,
	parameter int RAMP = RAMP_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] host_data,
	input wire logic host_last,
	input wire logic host_valid,
	output logic host_ready,
	output logic write_char_taken_strobe,
	input wire logic cmd_write,
	input wire logic cmd_fmark,
	input wire logic cmd_ident,
	input wire logic cmd_reverse,
	input wire logic dens_hi,
	input wire logic tape_end_near,
	input wire logic [8:0] rd_char,
	input wire logic rd_strobe,
	input wire logic rd_gap,
	output logic [8:0] trk,
	output logic wr_gate,
	output logic mot_rev,
	output logic [6:0] mot_speed,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic underrun
);
	localparam int CW = $clog2(DEPTH) + 1;
	ptf_fmt_e fst_q, fst_d;
	ptf_mot_e mst_q, mst_d;
	logic [HALF_W-1:0] cnt_q;
	logic half_q, dens_q, last_q, last_d, pop, done, urun;
	logic [N_W-1:0] n_q, n_d;
	logic [8:0] char_q, char_d, trk_q, trk_d;
	logic [TMR_W-1:0] tmr_q, tmr_d;
	logic want_wr_q, want_fm_q, want_id_q, want_rv_q;
	logic extra_q, extra_d, retr_q, retr_d;
	logic near_m_q, near_q, rdy_q, stb_q, urun_q, rev_q;
	logic [6:0] spd_q;
	logic [7:0] rec_q;
	logic [16:0] byt_q;
	logic [8:0] f_data;
	logic f_valid, f_in_rdy;
	logic [CW-1:0] f_cnt;
	logic zrun_q, sync_q, rv_q;
	logic [7:0] rdd_q;
	logic gate_q;

	// ------------------------------------------------------------
	// Host side and cache limits
	// ------------------------------------------------------------
	wire push = host_valid & rdy_q & f_in_rdy;
	wire [7:0] rec_d = rec_q + 8'(push & host_last) - 8'(pop & f_data[8]);
	wire [16:0] byt_d = byt_q + 17'(push) - 17'(pop);
	wire [31:0] lim_rec = near_q ? NEAR_REC_LIMIT : REC_LIMIT;
	wire [31:0] lim_byt = near_q ? NEAR_BYTE_LIMIT : BYTE_LIMIT;
	// Counts lag ready by a cycle, so stop one short of each limit.
	wire rdy_d = (32'(f_cnt) + 1 < DEPTH) &
		(32'(rec_q) + 1 < lim_rec) & (32'(byt_q) + 1 < lim_byt);

	ptf_fifo #(.W(9), .D(DEPTH)) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.in_data({host_last, host_data}),
		.in_valid(host_valid & rdy_q),
		.in_ready(f_in_rdy),
		.out_data(f_data),
		.out_valid(f_valid),
		.out_ready(pop),
		.count(f_cnt)
	);

	// ------------------------------------------------------------
	// Bit cell timing
	// ------------------------------------------------------------
	wire [HALF_W-1:0] half_len = dens_q ? HALF_3200_CYC : HALF_1600_CYC;
	wire active = fst_q != FS_IDLE;
	wire edge_ph = active & (cnt_q == '0) & half_q;
	wire edge_bt = active & (cnt_q == '0) & ~half_q;
	wire mot_ok = (mst_q == MS_RUN && tmr_q == '0) || mst_q == MS_WAIT;
	wire can_go = ~active & mot_ok;
	wire go_id = can_go & want_id_q;
	wire go_fm = can_go & ~want_id_q & want_fm_q;
	wire go_wr = can_go & ~want_id_q & ~want_fm_q & want_wr_q &
		(rec_q != '0);
	wire go = go_id | go_fm | go_wr;
	wire dat_q = fst_q inside {FS_PRE0, FS_PRE1, FS_DATA, FS_POST1,
		FS_POST0};
	wire dat_d = fst_d inside {FS_PRE0, FS_PRE1, FS_DATA, FS_POST1,
		FS_POST0};
	wire [3:0] burst_ch = dens_q ? 4'(CH_0) : 4'(CH_P);

	// ------------------------------------------------------------
	// Character sequence of a block, burst or file mark
	// ------------------------------------------------------------
	always_comb begin
		fst_d = fst_q;
		n_d = n_q;
		char_d = char_q;
		last_d = last_q;
		pop = 1'b0;
		done = 1'b0;
		urun = 1'b0;
		if (go) begin
			fst_d = go_id ? FS_IDB : (go_fm ? FS_FMK : FS_PRE0);
			n_d = 7'h01;
			char_d = '0;
			last_d = 1'b0;
		end else if (edge_ph) begin
			unique case (fst_q)
				FS_PRE0: begin
					if (n_q == AMBLE_ZEROS) begin
						fst_d = FS_PRE1;
						char_d = ALL_ONES;
					end else begin
						n_d = n_q + 7'h01;
					end
				end
				FS_PRE1, FS_DATA: begin
					// The block ends on the marked last byte, or early if the cache
					// runs empty; no check characters follow the data.
					if ((fst_q == FS_DATA && last_q) || !f_valid) begin
						fst_d = FS_POST1;
						char_d = ALL_ONES;
						urun = !(fst_q == FS_DATA && last_q);
					end else begin
						pop = 1'b1;
						fst_d = FS_DATA;
						char_d = ptf_chan(f_data[7:0]);
						last_d = f_data[8];
					end
				end
				FS_POST1: begin
					fst_d = FS_POST0;
					char_d = '0;
					n_d = 7'h01;
				end
				FS_POST0, FS_IDB, FS_FMK: begin
					if (n_q == (fst_q == FS_IDB ? BURST_CHARS :
						(fst_q == FS_FMK ? FMK_CHARS : AMBLE_ZEROS))) begin
						fst_d = FS_IDLE;
						done = 1'b1;
					end else begin
						n_d = n_q + 7'h01;
					end
				end
				FS_IDLE: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Head levels
	// ------------------------------------------------------------
	always_comb begin
		trk_d = trk_q;
		if (go) begin
			trk_d = go_wr ? ~ptf_tgt('0) : ERASE_V;
		end else if (fst_q == FS_FMK && (edge_ph | edge_bt)) begin
			trk_d = trk_q ^ FMK_MASK;
		end else if (fst_q == FS_IDB && edge_bt) begin
			trk_d[burst_ch] = ~trk_q[burst_ch];
		end else if (edge_ph && dat_q && dat_d) begin
			trk_d = ~ptf_tgt(char_d);
		end else if (edge_bt && dat_q) begin
			trk_d = ptf_tgt(char_q);
		end
	end

	// ------------------------------------------------------------
	// Reel motion and reinstruct timing
	// ------------------------------------------------------------
	always_comb begin
		mst_d = mst_q;
		tmr_d = tmr_q;
		extra_d = extra_q;
		retr_d = retr_q;
		unique case (mst_q)
			MS_STOP: begin
				if (want_rv_q) begin
					mst_d = MS_DECF;
					tmr_d = TMR_W'(RAMP);
					extra_d = 1'b1;
				end else if (want_id_q | want_fm_q |
					(want_wr_q & (rec_q != '0))) begin
					mst_d = MS_RUN;
					tmr_d = TMR_W'(RAMP);
				end
			end
			MS_RUN: begin
				if (tmr_q != '0) begin
					tmr_d = tmr_q - 1'b1;
				end else if (!active && !go) begin
					mst_d = MS_WAIT;
					tmr_d = TMR_W'(REINSTRUCT);
				end
			end
			MS_WAIT: begin
				if (want_rv_q) begin
					mst_d = MS_DECF;
					tmr_d = TMR_W'(RAMP);
					extra_d = 1'b1;
				end else if (go) begin
					mst_d = MS_RUN;
					tmr_d = '0;
				end else if (tmr_q == '0) begin
					mst_d = MS_DECF;
					tmr_d = TMR_W'(RAMP);
				end else begin
					tmr_d = tmr_q - 1'b1;
				end
			end
			MS_DECF, MS_ACCR, MS_DECR: begin
				if (tmr_q != '0) begin
					tmr_d = tmr_q - 1'b1;
				end else begin
					tmr_d = TMR_W'(RAMP);
					mst_d = mst_q == MS_DECF ? MS_ACCR :
						(mst_q == MS_ACCR ? MS_DECR : MS_STOP);
					if (mst_q == MS_DECR && extra_q) begin
						// The second pass retraces the first, forward.
						mst_d = MS_ACCR;
						extra_d = 1'b0;
						retr_d = 1'b1;
					end else if (mst_q == MS_DECR) begin
						retr_d = 1'b0;
					end
				end
			end
			default: mst_d = MS_STOP;
		endcase
	end
	wire rev_d = (mst_d == MS_ACCR || mst_d == MS_DECR) && !retr_d;
	// The tape keeps running at speed while the reinstruct timer runs,
	// so a timely command finds it still at recording speed.
	wire [6:0] spd_d = (mst_d == MS_RUN || mst_d == MS_WAIT ||
		mst_d == MS_ACCR) ? REC_IPS : 7'h00;

	// ------------------------------------------------------------
	// Read preamble hunt
	// ------------------------------------------------------------
	wire sync_d = rd_gap ? 1'b0 : (sync_q | (rd_strobe & zrun_q &
		rd_char == ALL_ONES));
	wire zrun_d = rd_gap ? 1'b0 : (rd_strobe && !sync_q ?
		rd_char == '0 : zrun_q);

	// ------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fst_q <= FS_IDLE;
			mst_q <= MS_STOP;
			cnt_q <= '0;
			half_q <= 1'b0;
			dens_q <= 1'b0;
			n_q <= '0;
			char_q <= '0;
			last_q <= 1'b0;
			trk_q <= ERASE_V;
			tmr_q <= '0;
			extra_q <= 1'b0;
			retr_q <= 1'b0;
			gate_q <= 1'b0;
		end else begin
			fst_q <= fst_d;
			mst_q <= mst_d;
			cnt_q <= go ? half_len - 1'b1 : (cnt_q == '0 ?
				half_len - 1'b1 : cnt_q - 1'b1);
			half_q <= go ? 1'b0 : half_q ^ (active & (cnt_q == '0));
			dens_q <= active ? dens_q : dens_hi;
			n_q <= n_d;
			char_q <= char_d;
			last_q <= last_d;
			trk_q <= trk_d;
			tmr_q <= tmr_d;
			extra_q <= extra_d;
			retr_q <= retr_d;
			gate_q <= fst_d != FS_IDLE;
		end
	end

	// A command arriving as its own flag clears is kept.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			want_wr_q <= 1'b0;
			want_fm_q <= 1'b0;
			want_id_q <= 1'b0;
			want_rv_q <= 1'b0;
			near_m_q <= 1'b0;
			near_q <= 1'b0;
			rec_q <= '0;
			byt_q <= '0;
			rdy_q <= 1'b0;
			stb_q <= 1'b0;
			urun_q <= 1'b0;
			rev_q <= 1'b0;
			spd_q <= '0;
		end else begin
			want_wr_q <= cmd_write | (want_wr_q & ~go_wr);
			want_fm_q <= cmd_fmark | (want_fm_q & ~go_fm);
			want_id_q <= cmd_ident | (want_id_q & ~go_id);
			want_rv_q <= cmd_reverse | (want_rv_q & ~(mst_d == MS_DECF));
			near_m_q <= tape_end_near;
			near_q <= near_m_q;
			rec_q <= rec_d;
			byt_q <= byt_d;
			rdy_q <= rdy_d;
			stb_q <= pop;
			urun_q <= urun | (urun_q & ~go_wr);
			rev_q <= rev_d;
			spd_q <= spd_d;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			zrun_q <= 1'b0;
			sync_q <= 1'b0;
			rv_q <= 1'b0;
			rdd_q <= '0;
		end else begin
			zrun_q <= zrun_d;
			sync_q <= sync_d;
			rv_q <= rd_strobe & sync_q & ~rd_gap;
			rdd_q <= rd_strobe ? {rd_char[0], rd_char[1], rd_char[2],
				rd_char[3], rd_char[4], rd_char[5], rd_char[6],
				rd_char[7]} : rdd_q;
		end
	end

	assign host_ready = rdy_q;
	assign write_char_taken_strobe = stb_q;
	assign trk = trk_q;
	assign wr_gate = gate_q;
	assign mot_rev = rev_q;
	assign mot_speed = spd_q;
	assign rd_data = rdd_q;
	assign rd_valid = rv_q;
	assign underrun = urun_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_decf_end;
		mst_q == MS_DECF ##1 mst_q != MS_DECF;
	endsequence
	sequence s_accr_end;
		mst_q == MS_ACCR ##1 mst_q != MS_ACCR;
	endsequence

	phase_flip_a: assert property (edge_ph && dat_q && dat_d |=>
		(trk_q ^ $past(trk_q)) == ~(char_q ^ $past(char_q)))
		else $error("phase time transition wrong");
	bit_flip_a: assert property (edge_bt && dat_q |=>
		trk_q == ~$past(trk_q) && trk_q == ptf_tgt(char_q))
		else $error("bit time transition missing");
	odd_parity_a: assert property (fst_q == FS_DATA |-> ^char_q)
		else $error("character parity not odd");
	pre_len_a: assert property (fst_q == FS_PRE0 ##1 fst_q == FS_PRE1
		|-> $past(n_q) == AMBLE_ZEROS && char_q == ALL_ONES)
		else $error("preamble length wrong");
	post_len_a: assert property (fst_q == FS_POST0 ##1
		fst_q == FS_IDLE |-> $past(n_q) == AMBLE_ZEROS)
		else $error("postamble length wrong");
	fmk_erase_a: assert property (fst_q == FS_FMK |->
		(trk_q & ~FMK_MASK) == (ERASE_V & ~FMK_MASK))
		else $error("file mark channel not erased");
	burst_erase_a: assert property (fst_q == FS_IDB && !dens_q |->
		trk_q[7:0] == ERASE_V[7:0])
		else $error("burst leaks into data channels");
	stall_lim_a: assert property (rdy_q |->
		32'(rec_q) < lim_rec && 32'(byt_q) < lim_byt)
		else $error("host ready beyond cache limit");
	repos_order_a: assert property (s_decf_end |->
		mst_q == MS_ACCR) else $error("reposition order broken");
	rev_peak_a: assert property (s_accr_end |->
		$past(spd_q) == REC_IPS) else $error("reverse peak speed wrong");
	take_strobe_a: assert property (pop |=>
		write_char_taken_strobe ##1 !write_char_taken_strobe || pop)
		else $error("taken strobe missing");
	wait_exp_a: assert property (mst_q == MS_WAIT && tmr_q == '0 &&
		!go |=> mst_q == MS_DECF) else $error("reinstruct expiry ignored");
endmodule

/* src/ptf_pkg.sv */
package ptf_pkg;
	localparam int CLK_NS = 5;
	localparam int CH_P = 8;
	localparam int CH_0 = 0;
	// Bit cells at the recording speed of 100 ips.
	localparam int CELL_1600_NS = 6250;
	localparam int CELL_3200_NS = 3125;
	localparam int HALF_W = 10;
	localparam logic [HALF_W-1:0] HALF_1600_CYC =
		HALF_W'(CELL_1600_NS / 2 / CLK_NS);
	localparam logic [HALF_W-1:0] HALF_3200_CYC =
		HALF_W'(CELL_3200_NS / 2 / CLK_NS);
	localparam int N_W = 7;
	localparam logic [N_W-1:0] AMBLE_ZEROS = 7'h28;
	localparam logic [N_W-1:0] FMK_CHARS = 7'h28;
	localparam logic [N_W-1:0] BURST_CHARS = 7'h40;
	localparam logic [8:0] FMK_MASK = 9'h1E5;
	localparam logic [8:0] ALL_ONES = 9'h1FF;
	localparam logic ERASE_POL = 1'b1;
	localparam logic [8:0] ERASE_V = {9{ERASE_POL}};
	localparam int REC_LIMIT = 150;
	localparam int BYTE_LIMIT = 65536;
	localparam int NEAR_REC_LIMIT = 8;
	localparam int NEAR_BYTE_LIMIT = 4096;
	localparam logic [6:0] REC_IPS = 7'h64;
	localparam int REINSTRUCT_NS = 2000000;
	localparam int RAMP_NS = 10000000;
	localparam int REINSTRUCT_CYC = REINSTRUCT_NS / CLK_NS;
	localparam int RAMP_CYC = RAMP_NS / CLK_NS;
	localparam int TMR_W = 24;
	typedef enum logic [2:0] {
		FS_IDLE = 3'h0, FS_PRE0 = 3'h1, FS_PRE1 = 3'h3, FS_DATA = 3'h2,
		FS_POST1 = 3'h6, FS_POST0 = 3'h7, FS_IDB = 3'h5, FS_FMK = 3'h4
	} ptf_fmt_e;
	typedef enum logic [2:0] {
		MS_STOP = 3'h0, MS_RUN = 3'h1, MS_WAIT = 3'h3, MS_DECF = 3'h2,
		MS_ACCR = 3'h6, MS_DECR = 3'h7
	} ptf_mot_e;
	// Channel 0 carries the byte's most significant bit.
	function automatic logic [8:0] ptf_chan(input logic [7:0] d);
		return {~^d, d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]};
	endfunction
	// Head level after the bit-time transition.
	function automatic logic [8:0] ptf_tgt(input logic [8:0] c);
		return c ^ {9{~ERASE_POL}};
	endfunction
endpackage

/* verif/ptf_host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host controller model
// ----------------------------------------------------------------
module ptf_host_model (
	input wire logic clk,
	input wire logic host_ready,
	output logic [7:0] host_data,
	output logic host_last,
	output logic host_valid
);
	initial begin
		host_data = 8'h00;
		host_last = 1'b0;
		host_valid = 1'b0;
	end

	// A byte and its record marker travel as one unit and are held
	// until an edge that finds the cache ready, or until we give up.
	task automatic send(input logic [7:0] d, input logic l, output bit ok);
		bit r;
		ok = 1'b0;
		r = 1'b0;
		host_data <= d;
		host_last <= l;
		host_valid <= 1'b1;
		for (int n = 0; n < 40 && !ok; n++) begin
			@(negedge clk) r = host_ready;
			@(posedge clk) ok = r;
		end
		if (!ok) begin
			idle();
		end
	endtask

	// Released lines show the inverse so a stale byte cannot pass.
	task automatic idle();
		host_valid <= 1'b0;
		host_last <= ~host_last;
		host_data <= ~host_data;
	endtask
endmodule

/* verif/tb_phase_encoded_tape_block_formatter.sv */
`timescale 1ns/1ps
module tb_phase_encoded_tape_block_formatter import ptf_pkg::*;;
	localparam int RAMP_T = 20;
	localparam int REIN_T = 50;
	logic clk, rst_b, host_last, host_valid, host_ready, wstb;
	logic [7:0] host_data, rd_data, rv_last;
	logic cmd_write, cmd_reverse, dens_hi, tape_end_near;
	logic cmd_fmark, cmd_ident;
	logic rd_strobe, rd_gap, wr_gate, mot_rev, rd_valid, underrun;
	logic [8:0] rd_char, trk;
	logic [6:0] mot_speed;
	int err_count = 0;
	int tests_run = 0;
	int stb_cnt = 0;
	int rv_cnt = 0;
	int hh;

	ptf_formatter #(.DEPTH(16), .REINSTRUCT(REIN_T), .RAMP(RAMP_T))
	i_ptf_formatter (
		.clk(clk), .rst_b(rst_b), .host_data(host_data),
		.host_last(host_last), .host_valid(host_valid),
		.host_ready(host_ready), .write_char_taken_strobe(wstb),
		.cmd_write(cmd_write), .cmd_fmark(cmd_fmark),
		.cmd_ident(cmd_ident),
		.cmd_reverse(cmd_reverse), .dens_hi(dens_hi),
		.tape_end_near(tape_end_near), .rd_char(rd_char),
		.rd_strobe(rd_strobe), .rd_gap(rd_gap), .trk(trk),
		.wr_gate(wr_gate), .mot_rev(mot_rev), .mot_speed(mot_speed),
		.rd_data(rd_data), .rd_valid(rd_valid), .underrun(underrun)
	);

	ptf_host_model i_ptf_host_model (
		.clk(clk), .host_ready(host_ready), .host_data(host_data),
		.host_last(host_last), .host_valid(host_valid)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Sampled on the falling edge so flop updates have settled.
	always @(negedge clk) begin
		if (wstb === 1'b1) stb_cnt++;
		if (rd_valid === 1'b1) begin
			rv_cnt++;
			rv_last = rd_data;
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [8:0] enc(input logic [7:0] d);
		enc[8] = ~^d;
		for (int k = 0; k < 8; k++) enc[k] = d[7 - k];
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp,
		input string what);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what,
				seen, exp);
		end
	endtask

	task automatic complete_run;
		if (err_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic do_reset;
		@(posedge clk);
		rst_b <= 1'b0;
		@(negedge clk);
		check({host_ready, wstb, wr_gate, mot_rev, rd_valid, underrun,
			mot_speed, 3'h0}, 16'h0000, "reset outputs");
		check(16'(trk), 16'h01FF, "reset head");
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
	endtask

	task automatic rd_put(input logic [8:0] c);
		rd_char <= c;
		rd_strobe <= 1'b1;
		@(posedge clk);
		rd_strobe <= 1'b0;
		rd_char <= ~c;
		@(posedge clk);
	endtask

	task automatic mot_at(input int n, input logic rev, input logic [6:0] s);
		repeat (n) @(negedge clk);
		check(16'({mot_rev, mot_speed}), 16'({rev, s}), "motion");
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_read;
		int n0;
		rd_gap <= 1'b1;
		@(posedge clk);
		rd_gap <= 1'b0;
		repeat (3) rd_put(9'h000);
		rd_put(9'h1FF);
		n0 = rv_cnt;
		rd_put(enc(8'hA5));
		repeat (2) @(posedge clk);
		check(16'(rv_cnt - n0), 16'h0001, "read count");
		check(16'(rv_last), 16'h00A5, "read byte");
		// After a gap an all-ones char without a zero run must not sync.
		rd_gap <= 1'b1;
		@(posedge clk);
		rd_gap <= 1'b0;
		rd_put(9'h1FF);
		rd_put(enc(8'h3C));
		repeat (2) @(posedge clk);
		check(16'(rv_cnt - n0), 16'h0001, "unsynced read");
	endtask

	task automatic test_block;
		logic [8:0] cs[$];
		bit ok;
		int n;
		int s0;
		cs = {};
		repeat (40) cs.push_back(9'h000);
		cs.push_back(9'h1FF);
		cs.push_back(enc(8'hC3));
		cs.push_back(enc(8'h07));
		cs.push_back(9'h1FF);
		repeat (40) cs.push_back(9'h000);
		s0 = stb_cnt;
		i_ptf_host_model.send(8'hC3, 1'b0, ok);
		i_ptf_host_model.send(8'h07, 1'b1, ok);
		i_ptf_host_model.idle();
		cmd_write <= 1'b1;
		@(posedge clk);
		cmd_write <= 1'b0;
		n = 0;
		while (wr_gate !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		check(16'(mot_speed), 16'h0064, "write speed");
		foreach (cs[i]) begin
			repeat (hh) @(negedge clk);
			check({6'h00, wr_gate, trk}, {7'h01, cs[i] ^ 9'h1FF},
				"phase half");
			repeat (2 * hh) @(negedge clk);
			check({6'h00, wr_gate, trk}, {7'h01, cs[i]},
				"bit half");
			repeat (hh) @(negedge clk);
		end
		repeat (4) @(negedge clk);
		check(16'({wr_gate, underrun}), 16'h0000, "block end");
		check(16'(stb_cnt - s0), 16'h0002, "strobes");
	endtask

	task automatic test_motion;
		int n;
		check(16'(mot_speed), 16'h0064, "waiting speed");
		n = 0;
		while (mot_rev !== 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
		check(16'(n >= 60 && n <= 76), 16'h0001, "reinstruct");
		mot_at(5, 1'b1, 7'h64);
		mot_at(21, 1'b1, 7'h00);
		mot_at(21, 1'b0, 7'h00);
	endtask

	task automatic test_reverse;
		int n;
		@(posedge clk);
		cmd_reverse <= 1'b1;
		@(posedge clk);
		cmd_reverse <= 1'b0;
		n = 0;
		while (mot_rev !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		check(16'(n >= 15 && n <= 30), 16'h0001, "reverse start");
		mot_at(5, 1'b1, 7'h64);
		n = 0;
		while (mot_rev !== 1'b0 && n < 100) begin
			@(negedge clk);
			n++;
		end
		check(16'(n >= 30 && n <= 45), 16'h0001, "first pass");
		mot_at(5, 1'b0, 7'h64);
		mot_at(21, 1'b0, 7'h00);
		mot_at(30, 1'b0, 7'h00);
	endtask

	task automatic wait_gate;
		int n;
		n = 0;
		while (wr_gate !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
	endtask

	// A file mark flips its channel set at every half cell.
	task automatic test_fmark;
		@(posedge clk);
		cmd_fmark <= 1'b1;
		@(posedge clk);
		cmd_fmark <= 1'b0;
		wait_gate();
		repeat (hh) @(negedge clk);
		check({6'h00, wr_gate, trk}, 16'h03FF, "mark start");
		repeat (2 * hh) @(negedge clk);
		check({6'h00, wr_gate, trk}, 16'h021A, "mark bit");
		repeat (2 * hh) @(negedge clk);
		check({6'h00, wr_gate, trk}, 16'h03FF, "mark phase");
	endtask

	// At the low density the burst flips channel P once per cell.
	task automatic test_ident;
		dens_hi <= 1'b0;
		@(posedge clk);
		cmd_ident <= 1'b1;
		@(posedge clk);
		cmd_ident <= 1'b0;
		wait_gate();
		repeat (2 * hh) @(negedge clk);
		check({6'h00, wr_gate, trk}, 16'h03FF, "burst start");
		repeat (4 * hh) @(negedge clk);
		check({6'h00, wr_gate, trk}, 16'h02FF, "burst bit");
		repeat (8 * hh) @(negedge clk);
		check({6'h00, wr_gate, trk}, 16'h03FF, "burst cell");
	endtask

	task automatic test_fill(input logic near, input int lo, input int hi);
		int acc;
		bit ok;
		acc = 0;
		ok = 1'b1;
		tape_end_near <= near;
		repeat (5) @(posedge clk);
		while (ok && acc < 20) begin
			i_ptf_host_model.send(8'(acc), 1'b1, ok);
			if (ok) acc++;
		end
		if (ok) i_ptf_host_model.idle();
		check(16'(acc >= lo && acc <= hi), 16'h0001,
			"bytes cached");
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		rst_b = 1'b0;
		cmd_write = 1'b0;
		cmd_reverse = 1'b0;
		cmd_fmark = 1'b0;
		cmd_ident = 1'b0;
		dens_hi = 1'b1;
		tape_end_near = 1'b0;
		rd_char = 9'h000;
		rd_strobe = 1'b0;
		rd_gap = 1'b0;
		hh = HALF_3200_CYC / 2;
		@(posedge clk);
		do_reset();
		test_read();
		test_block();
		test_motion();
		test_reverse();
		test_fmark();
		do_reset();
		test_ident();
		do_reset();
		test_fill(1'b1, 7, 9);
		do_reset();
		test_fill(1'b0, 15, 16);
		complete_run();
	end

	// The long block write dominates; this allows about half again.
	initial begin
		#400000;
		err_count++;
		complete_run();
	end
endmodule
